// >>> logic/cib_host.sv
// Host end of the interrupt and DMA request drive-back cycle, with command strobe control.
// Assumes bus_clock_i is a slow free-running pin clock sampled by clk_i; Wishbone classic slave.
`default_nettype none
module cib_host
   import cib_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Bus pins
   input wire logic bus_clock_i,
   input wire logic ale_i,
   input wire logic cycle_pending_i,
   input wire logic select_backoff_line_i,
   output logic select_backoff_line_o,
   output logic select_backoff_line_oe_o,
   input wire logic [15:0] muxed_addr_data_i,
   output logic [15:0] muxed_addr_data_o,
   output logic muxed_addr_data_oe_o,
   output logic cmd_n_o,
   output logic nows_n_o,
   output logic std_timing_flag_o,
   output logic abort_cycle_o,
   output logic block_io_dma_o,
   // AT controller commands, active low
   input wire logic memory_read_cmd_n_i,
   input wire logic memory_write_cmd_n_i,
   input wire logic io_read_cmd_n_i,
   input wire logic io_write_cmd_n_i,
   // Interrupt and DMA outputs, with the system DMA requests coming in
   input wire logic [7:0] sys_drq_i,
   output logic [15:0] irq_o,
   output logic [7:0] drq_o
);
   logic bclk_s, bsel_s, bale_s, bclk_d;
   logic [15:0] mad_s, mad_d;
   logic rise, fall;
   cib_state_e state;
   logic [2:0] ctrl;
   logic [7:0] drq_lvl;
   logic in_cycle;
   logic backoff_req;

   cib_sync u_clk (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1), .d_i(bus_clock_i),
      .q_o(bclk_s));
   cib_sync u_sel (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1),
      .d_i(select_backoff_line_i), .q_o(bsel_s));
   cib_sync u_ale (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1), .d_i(ale_i), .q_o(bale_s));
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_mad
         cib_sync u_m (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1),
            .d_i(muxed_addr_data_i[g]), .q_o(mad_s[g]));
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_d <= 1'b1;
      end else begin
         bclk_d <= bclk_s;
      end
   end
   assign rise = bclk_s & ~bclk_d;
   assign fall = ~bclk_s & bclk_d;

   // Data is taken from the sample before the edge was seen; the far side may change
   // its lines right at the edge, so the post-edge sample is not safe to latch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mad_d <= 16'hffff;
      end else begin
         mad_d <= mad_s;
      end
   end

   // Backoff only counts while latch enable is low, and only while the line is not ours
   assign backoff_req = ~bsel_s & ~bale_s & ~select_backoff_line_oe_o;

   // Drive-back sequencer; bus clock edges are seen two to three system cycles late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= CIB_IDLE;
      end else begin
         case (state)
            CIB_IDLE: begin
               if (rise && backoff_req && ctrl[CIB_CTRL_ENA]) begin
                  state <= CIB_HOLD;
               end
            end
            CIB_HOLD: begin
               if (fall && !cycle_pending_i) begin
                  state <= CIB_PRE;
               end
            end
            CIB_PRE: begin
               if (rise) begin
                  state <= CIB_IRQ;
               end
            end
            CIB_IRQ: begin
               if (rise) begin
                  state <= CIB_DRQ;
               end
            end
            CIB_DRQ: begin
               if (rise) begin
                  state <= CIB_DONE;
               end
            end
            CIB_DONE: begin
               if (rise) begin
                  state <= CIB_IDLE;
               end
            end
            default: state <= CIB_IDLE;
         endcase
      end
   end
   assign in_cycle = (state != CIB_IDLE);

   // Pin drivers; the precharge pulls all lines high, then the lines are released
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         muxed_addr_data_o <= 16'hffff;
         muxed_addr_data_oe_o <= 1'b0;
         select_backoff_line_o <= 1'b1;
         select_backoff_line_oe_o <= 1'b0;
      end else begin
         muxed_addr_data_o <= 16'hffff;
         muxed_addr_data_oe_o <= (state == CIB_PRE);
         select_backoff_line_o <= 1'b0;
         select_backoff_line_oe_o <= (state == CIB_IRQ) || (state == CIB_DRQ);
      end
   end

   // Command strobe: drive-back strobe or AND of the four commands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_n_o <= 1'b1;
         nows_n_o <= 1'b1;
         std_timing_flag_o <= 1'b0;
         abort_cycle_o <= 1'b0;
         block_io_dma_o <= 1'b0;
      end else begin
         cmd_n_o <= ~((state == CIB_IRQ) || (state == CIB_DRQ)) &
            memory_read_cmd_n_i & memory_write_cmd_n_i &
            io_read_cmd_n_i & io_write_cmd_n_i;
         nows_n_o <= bsel_s | ~bale_s | (memory_read_cmd_n_i & memory_write_cmd_n_i);
         std_timing_flag_o <= ctrl[CIB_CTRL_FAST];
         abort_cycle_o <= (state == CIB_IDLE) && rise && backoff_req
            && ctrl[CIB_CTRL_ENA];
         block_io_dma_o <= in_cycle;
      end
   end

   // Interrupt and request latches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= CIB_IRQ_RST;
         drq_lvl <= 8'h00;
      end else if (rise && ~bsel_s && ~cmd_n_o) begin
         if (state == CIB_IRQ) begin
            irq_o <= ~mad_d;
         end
         if (state == CIB_DRQ) begin
            drq_lvl <= ((~mad_d[15:8] & mad_d[7:0]) | (mad_d[15:8] & drq_lvl))
               & CIB_DRQ_VALID;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drq_o <= 8'h00;
      end else begin
         drq_o <= (in_cycle || (rise && backoff_req)) ? 8'h00 : (drq_lvl | sys_drq_i);
      end
   end

   // Wishbone register file, one-cycle answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl <= CIB_CTRL_RST;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i && wb_adr_i == CIB_ADR_CTRL && wb_sel_i[0]) begin
               ctrl <= wb_dat_i[2:0];
            end
            case (wb_adr_i)
               CIB_ADR_CTRL: wb_dat_o <= {29'h0, ctrl};
               CIB_ADR_STAT: wb_dat_o <= {29'h0, state};
               CIB_ADR_IRQ: wb_dat_o <= {16'h0, irq_o};
               CIB_ADR_DRQ: wb_dat_o <= {24'h0, drq_lvl};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // Pin-side checks lag the sequencer by one register stage
   AST_ABORT_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
      abort_cycle_o |=> block_io_dma_o) else $error("abort without block");
   AST_BLOCK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == CIB_HOLD) |=> block_io_dma_o)
      else $error("operations not blocked while waiting");
   AST_PRE_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == CIB_PRE) |=> muxed_addr_data_oe_o && muxed_addr_data_o == 16'hffff)
      else $error("precharge missing");
   AST_MAD_PRE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      muxed_addr_data_oe_o |-> $past(state) == CIB_PRE)
      else $error("lines driven outside precharge");
   AST_DRQ_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == CIB_IRQ) |=> drq_o == 8'h00) else $error("drq not masked");
   AST_DRQ_OR: assert property (@(posedge clk_i) disable iff (rst_i)
      (!in_cycle && !(rise && backoff_req)) |=> drq_o == ($past(drq_lvl) | $past(sys_drq_i)))
      else $error("request levels not merged");
   AST_STROBE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == CIB_IRQ) |=> !cmd_n_o) else $error("strobe not asserted");
   AST_IRQ_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == CIB_IRQ && rise && !bsel_s && !cmd_n_o) |=> irq_o == ~$past(mad_d))
      else $error("interrupts not latched");
   AST_END_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(in_cycle) |=> ##1 !select_backoff_line_oe_o && !muxed_addr_data_oe_o)
      else $error("lines still driven");
   AST_END_STROBE: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == CIB_DONE && memory_read_cmd_n_i && memory_write_cmd_n_i && io_read_cmd_n_i
      && io_write_cmd_n_i) |=> cmd_n_o && !select_backoff_line_oe_o)
      else $error("strobe or backoff not released");
   AST_CMD_AND: assert property (@(posedge clk_i) disable iff (rst_i)
      (!in_cycle && !io_read_cmd_n_i) |=> !cmd_n_o) else $error("strobe not and");
   AST_NOWS_MEM: assert property (@(posedge clk_i) disable iff (rst_i)
      (!bsel_s && bale_s && !memory_read_cmd_n_i) |=> !nows_n_o)
      else $error("no wait state missing");
   AST_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 std_timing_flag_o == $past(ctrl[CIB_CTRL_FAST])) else $error("flag wrong");
   AST_RSV_CH4: assert property (@(posedge clk_i) disable iff (rst_i)
      !drq_lvl[4]) else $error("channel four set");
   AST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(state == CIB_DRQ) |-> $past(state) == CIB_IRQ) else $error("order");
   COV_CYCLE: cover property (@(posedge clk_i) state == CIB_DONE);
   COV_ABORT: cover property (@(posedge clk_i) abort_cycle_o);
   COV_DRQ: cover property (@(posedge clk_i) drq_lvl != 8'h00);
   COV_IRQ: cover property (@(posedge clk_i) irq_o != 16'h0000);
endmodule : cib_host
`default_nettype wire

// >>> shared/cib_pkg.sv
// Constants for the drive-back host block: register map, fields, reset values, state encoding.
// Assumes a 100 MHz system clock and a Wishbone classic slave port for software.
// Operation
// - Select/backoff low while address latch enable low means a peripheral requests backoff.
// - Backoff before a planned latch enable aborts that cycle; new I/O and DMA blocked.
// - Host drives all lines high half a clock, then asserts strobe and backoff low.
// - Host latches interrupts on rising edge with backoff and strobe low, then owns backoff.
// - Next rising edge latches request levels only for channels whose enable bit is low.
// - Latched request levels hold until changed and are ORed with system requests.
// - On backoff, host masks all requests to its DMA controller until the cycle ends.
// - Host ends the cycle by releasing strobe and backoff on a rising bus clock edge.
// - Command strobe is the AND of the four active-low command signals.
// - Memory cycles are zero wait: no-wait-state asserted whenever select is seen; here also only while latch enable is high.
// - Timing flag zero for standard timing, one only for one-clock fast strobe.
// - No device drives the system data bus between bus cycles.
// - Bus clock stops only after a stop-clock broadcast; slower clocks allowed.
`default_nettype none
package cib_pkg;
   localparam logic [3:0] CIB_ADR_CTRL = 4'h0;
   localparam logic [3:0] CIB_ADR_STAT = 4'h4;
   localparam logic [3:0] CIB_ADR_IRQ = 4'h8;
   localparam logic [3:0] CIB_ADR_DRQ = 4'hc;
   localparam int CIB_CTRL_FAST = 0;
   localparam int CIB_CTRL_ENA = 1;
   localparam int CIB_CTRL_STOPOK = 2;
   localparam logic [2:0] CIB_CTRL_RST = 3'h2;
   localparam logic [7:0] CIB_DRQ_VALID = 8'hef;
   localparam logic [15:0] CIB_IRQ_RST = 16'h0000;
   typedef enum logic [2:0] {
      CIB_IDLE = 3'b000,
      CIB_HOLD = 3'b001,
      CIB_PRE = 3'b011,
      CIB_IRQ = 3'b010,
      CIB_DRQ = 3'b110,
      CIB_DONE = 3'b111
   } cib_state_e;
endpackage : cib_pkg
`default_nettype wire

// >>> logic/cib_sync.sv
// Two-flop synchroniser for one bus pin level.
// Assumes the pin is asynchronous to clk_i.
`default_nettype none
module cib_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rst_val_i,
   // Level
   input wire logic d_i,
   output logic q_o
);
   logic s1;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= rst_val_i;
         q_o <= rst_val_i;
      end else begin
         s1 <= d_i;
         q_o <= s1;
      end
   end
endmodule : cib_sync
`default_nettype wire

// >>> testbench/cib_periph.sv
// Behavioural peripheral that requests and runs one drive-back cycle.
// Assumes open-drain style lines with pull-ups resolved by the bench.
`default_nettype none
module cib_periph (
   input wire logic bclk_i,
   input wire logic sel_i,
   input wire logic ale_i,
   input wire logic fast_i,
   input wire logic cmd_n_i,
   input wire logic req_i,
   input wire logic [15:0] irq_i,
   input wire logic [7:0] chg_i,
   input wire logic [7:0] lvl_i,
   output logic sel_oe_o,
   output logic rdy_o,
   output logic [15:0] mad_o,
   output logic [15:0] mad_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph = 0;
   int idle = 0;
   initial begin
      sel_oe_o = 0;
      mad_o = 16'h0000;
      mad_oe_o = 16'h0000;
   end
   // Ready drops on every fast strobe, the non-default setting of the programmable option
   assign rdy_o = ~(fast_i & ~cmd_n_i);
   always @(bclk_i) begin
      if (bclk_i) begin
         idle <= (sel_i && cmd_n_i && !ale_i) ? idle + 1 : 0;
         if (ph == 0 && req_i && idle >= 2) begin
            sel_oe_o <= 1;
            ph <= 1;
         end else if (ph == 2) begin
            sel_oe_o <= 0;
            mad_o <= 16'hffff;
            ph <= 3;
         end else if (ph == 4) begin
            ph <= 5;
         end
      end else begin
         if (ph == 1 && !cmd_n_i) begin
            mad_o <= 16'h0000;
            mad_oe_o <= irq_i;
            ph <= 2;
         end else if (ph == 3) begin
            mad_o <= {8'h00, lvl_i};
            mad_oe_o <= {chg_i, chg_i};
            ph <= 4;
         end else if (ph == 5) begin
            mad_oe_o <= 16'h0000;
            ph <= 0;
         end
      end
   end
endmodule : cib_periph
`default_nettype wire

// >>> testbench/tb_top.sv
// Bench for the drive-back host: random drive-back cycles, strobe and flag checks.
// Assumes pull-ups on the shared lines; peripheral model on the far side.
`default_nettype none
module tb_top;
   import cib_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, bclk = 0, cyc = 0, stb = 0, we = 0, ack, req = 0, pend = 0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic [3:0] cmds = 4'hf;
   logic [7:0] sys = 8'h00, chg = 8'h00, lvl = 8'h00, drq, lat = 8'h00, dmax;
   logic [15:0] irq = 16'h0000, irq_o, mo, ho, mad_oe;
   logic hso, hsoe, soe, cmd_n, nows_n, flag, abrt, blk, moe, rdy;
   logic ale = 0, psel = 0, abrt_seen = 0, pre_seen = 0;
   wire logic sel_w = hsoe ? hso : ((soe || psel) ? 1'b0 : 1'b1);
   wire logic [15:0] mad_w = moe ? ho : (mo | ~mad_oe);
   int error_cnt = 0, check_count = 0, cycles = 0, i, k;
   logic [15:0] lf = 16'd34459;
   always #5 clk_i = ~clk_i;
   always #40 bclk = ~bclk;
   cib_periph per (.bclk_i(bclk), .sel_i(sel_w), .ale_i(ale), .fast_i(flag), .cmd_n_i(cmd_n),
      .req_i(req), .irq_i(irq), .chg_i(chg), .lvl_i(lvl), .sel_oe_o(soe), .rdy_o(rdy),
      .mad_o(mo), .mad_oe_o(mad_oe));
   cib_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .bus_clock_i(bclk), .ale_i(ale), .cycle_pending_i(pend), .select_backoff_line_i(sel_w),
      .select_backoff_line_o(hso), .select_backoff_line_oe_o(hsoe), .muxed_addr_data_i(mad_w),
      .muxed_addr_data_o(ho), .muxed_addr_data_oe_o(moe), .cmd_n_o(cmd_n), .nows_n_o(nows_n),
      .std_timing_flag_o(flag), .abort_cycle_o(abrt), .block_io_dma_o(blk),
      .memory_read_cmd_n_i(cmds[0]), .memory_write_cmd_n_i(cmds[1]), .io_read_cmd_n_i(cmds[2]),
      .io_write_cmd_n_i(cmds[3]), .sys_drq_i(sys), .irq_o(irq_o), .drq_o(drq));
   function automatic logic [15:0] rnd(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : rnd
   function automatic logic [7:0] nxt(input logic [7:0] o, c, l);
      return ((o & ~c) | (l & c)) & CIB_DRQ_VALID;
   endfunction : nxt
   task automatic check(input string n, input logic [31:0] e, s);
      check_count++;
      if (e !== s) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
   endtask : wb
   task automatic final_report;
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (abrt) abrt_seen <= 1'b1;
      if (moe && ho == 16'hffff) pre_seen <= 1'b1;
      if (cycles == 30000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(1'b0, CIB_ADR_CTRL, 32'h0);
      check("ctrl", {29'h0, CIB_CTRL_RST}, rd);
      wb(1'b0, 4'h2, 32'h0);
      check("unmapped", 32'h0, rd);
      check("irq_rst", CIB_IRQ_RST, irq_o);
      for (k = 0; k < 2; k++) begin
         wb(1'b1, CIB_ADR_CTRL, {31'h1, k[0]});
         repeat (2) @(posedge clk_i);
         check("flag", k[0], flag);
      end
      for (k = 0; k < 6; k++) begin
         lf = rnd(lf);
         cmds <= (k < 4) ? ~(4'h1 << k) : lf[3:0];
         repeat (3) @(posedge clk_i);
         check("cmd", &cmds, cmd_n);
         check("ready", &cmds, rdy);
      end
      ale <= 1'b1;
      psel <= 1'b1;
      cmds <= 4'he;
      repeat (4) @(posedge clk_i);
      check("nows", 1'b0, nows_n);
      cmds <= 4'hf;
      repeat (2) @(posedge clk_i);
      check("nows_off", 1'b1, nows_n);
      psel <= 1'b0;
      repeat (4) @(posedge clk_i);
      ale <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (k = 0; k < 5; k++) begin
         lf = rnd(lf);
         irq <= (k == 0) ? 16'hffff : lf;
         lf = rnd(lf);
         chg <= (k == 1) ? CIB_DRQ_VALID : lf[7:0] & CIB_DRQ_VALID;
         lvl <= lf[15:8];
         sys <= 8'h00;
         pend <= 1;
         req <= 1;
         repeat (40) @(posedge clk_i);
         check("held_by_pending", 1'b1, cmd_n);
         pend <= 0;
         for (i = 0; i < 400 && cmd_n !== 1'b0; i++) @(posedge clk_i);
         req <= 0;
         check("strobe", 1'b0, cmd_n);
         check("backoff_drive", 1'b1, hsoe);
         check("backoff_level", 1'b0, hso);
         check("block", 1'b1, blk);
         check("dma_mask", 8'h00, drq);
         for (i = 0; i < 400 && cmd_n !== 1'b1; i++) @(posedge clk_i);
         check("dma_mask_end", 8'h00, drq);
         lat = nxt(lat, chg, lvl);
         lf = rnd(lf);
         sys <= lf[7:0];
         for (i = 0; i < 400 && blk !== 1'b0; i++) @(posedge clk_i);
         check("idle_again", 1'b0, blk);
         check("irq", irq, irq_o);
         check("drq", lat | sys, drq);
         check("release", 1'b0, hsoe);
         wb(1'b0, CIB_ADR_DRQ, 32'h0);
         check("drq_reg", {24'h0, lat}, rd);
         wb(1'b0, CIB_ADR_STAT, 32'h0);
         check("state_idle", {29'h0, CIB_IDLE}, rd);
         repeat (20) @(posedge clk_i);
      end
      check("abort_seen", 1'b1, abrt_seen);
      check("precharge_seen", 1'b1, pre_seen);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("flag_rst", 1'b0, flag);
      wb(1'b0, CIB_ADR_CTRL, 32'h0);
      check("ctrl_rst", {29'h0, CIB_CTRL_RST}, rd);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
